/* design/qmc_update_sync_select.sv */
// register bank with double-buffered quadrature correction words
`timescale 1ns/1ps
`default_nettype none
`include "qmc_update_params.svh"
//------------------------------------------------------------
// Contract
// - bits 15:12 pick update sources for AB offset shadows
// - bits 11:8 pick update sources for CD offset shadows
// - bits 7:4 pick update sources for AB correction shadows
// - bits 3:0 pick update sources for CD correction shadows
// - a set bit enables its event; any enabled event updates
// - select register at 0x1e resets to 0x1111
//------------------------------------------------------------
module qmc_update_sync_select (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic [5:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic        sync_pin_in,
    input  wire logic        timing_reference_pin_in,
    output logic      [15:0] rdata_out,
    output logic      [15:0] ab_offset_out,
    output logic      [15:0] cd_offset_out,
    output logic      [15:0] ab_correction_out,
    output logic      [15:0] cd_correction_out,
    output logic      [3:0]  update_out
);
    qmc_update_pkg::word_t update_source_select;
    logic                  strobe;
    qmc_update_pkg::word_t shadow [4];
    qmc_update_pkg::word_t active [4];
    logic [5:0]            gaddr [4];
    qmc_update_if          upd ();

    assign gaddr[0] = `AB_OFFSET_ADDR;
    assign gaddr[1] = `CD_OFFSET_ADDR;
    assign gaddr[2] = `AB_CORRECTION_ADDR;
    assign gaddr[3] = `CD_CORRECTION_ADDR;

    qmc_update_selector u_sel (
        .select_in (update_source_select),
        .strobe_in (strobe),
        .sync_in   (sync_pin_in),
        .timing_in (timing_reference_pin_in),
        .upd       (upd)
    );

    //------------------------------------------------------------
    // control registers
    //------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            update_source_select <= `UPDATE_SOURCE_SELECT_RESET;
        end else if (wr_in && addr_in == `UPDATE_SOURCE_SELECT_ADDR) begin
            update_source_select <= wdata_in;
        end
    end

    // strobe stays asserted while the bit is set
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            strobe <= 1'b0;
        end else if (wr_in && addr_in == `STROBE_CTRL_ADDR) begin
            strobe <= wdata_in[`STROBE_BIT];
        end
    end

    //------------------------------------------------------------
    // shadow and active copies
    //------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `NUM_GROUPS; g++) begin : g_buf
            assign upd.group_write[g] = wr_in && addr_in == gaddr[g];
            always_ff @(posedge clk_sys_in) begin
                if (!rst_n_in) begin
                    shadow[g] <= `ZERO_DATA;
                end else if (upd.group_write[g]) begin
                    shadow[g] <= wdata_in;
                end
            end
            // a write-triggered update takes the word being written
            always_ff @(posedge clk_sys_in) begin
                if (!rst_n_in) begin
                    active[g] <= `ZERO_DATA;
                end else if (upd.group_update[g]) begin
                    active[g] <= upd.group_write[g] ? wdata_in : shadow[g];
                end
            end
            always_ff @(posedge clk_sys_in) begin
                if (!rst_n_in) begin
                    update_out[g] <= 1'b0;
                end else begin
                    update_out[g] <= upd.group_update[g];
                end
            end
        end
    endgenerate

    assign ab_offset_out     = active[0];
    assign cd_offset_out     = active[1];
    assign ab_correction_out = active[2];
    assign cd_correction_out = active[3];

    //------------------------------------------------------------
    // read port
    //------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rdata_out <= `ZERO_DATA;
        end else if (rd_in) begin
            if (addr_in == `UPDATE_SOURCE_SELECT_ADDR) begin
                rdata_out <= update_source_select;
            end else if (addr_in == `STROBE_CTRL_ADDR) begin
                rdata_out <= 16'(strobe) << `STROBE_BIT;
            end else if (addr_in == `AB_OFFSET_ADDR) begin
                rdata_out <= shadow[0];
            end else if (addr_in == `CD_OFFSET_ADDR) begin
                rdata_out <= shadow[1];
            end else if (addr_in == `AB_CORRECTION_ADDR) begin
                rdata_out <= shadow[2];
            end else if (addr_in == `CD_CORRECTION_ADDR) begin
                rdata_out <= shadow[3];
            end else begin
                rdata_out <= `ZERO_DATA;
            end
        end else begin
            rdata_out <= `ZERO_DATA;
        end
    end

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    a_select_reset: assert property (@(posedge clk_sys_in)
        !rst_n_in |=> update_source_select == `UPDATE_SOURCE_SELECT_RESET)
        else $error("select register reset value wrong");
    a_select_write: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (wr_in && addr_in == `UPDATE_SOURCE_SELECT_ADDR)
        |=> update_source_select == $past(wdata_in))
        else $error("select register write lost");
    a_select_readback: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (rd_in && addr_in == `UPDATE_SOURCE_SELECT_ADDR)
        |=> rdata_out == $past(update_source_select))
        else $error("select register read back wrong");
    a_strobe_reset: assert property (@(posedge clk_sys_in)
        !rst_n_in |=> !strobe)
        else $error("strobe bit not cleared by reset");
    a_strobe_follow: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (wr_in && addr_in == `STROBE_CTRL_ADDR)
        |=> strobe == $past(wdata_in[`STROBE_BIT]))
        else $error("strobe bit write lost");

    //------------------------------------------------------------
    // ab offset group
    //------------------------------------------------------------
    a_write_update_ab: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (wr_in && addr_in == `AB_OFFSET_ADDR
            && update_source_select[`AB_OFFSET_LSB + `SRC_WRITE])
        |=> ab_offset_out == $past(wdata_in))
        else $error("ab offset auto update missed");
    a_aboff_strobe: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (strobe && update_source_select[`AB_OFFSET_LSB + `SRC_STROBE] && !wr_in)
        |=> ab_offset_out == $past(shadow[0]))
        else $error("ab offset strobe update missed");
    a_aboff_sync: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (sync_pin_in && update_source_select[`AB_OFFSET_LSB + `SRC_SYNC] && !wr_in)
        |=> ab_offset_out == $past(shadow[0]))
        else $error("ab offset sync update missed");
    a_aboff_timing: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (timing_reference_pin_in && update_source_select[`AB_OFFSET_LSB + `SRC_TIMING]
            && !wr_in)
        |=> ab_offset_out == $past(shadow[0]))
        else $error("ab offset timing update missed");
    a_no_event_hold: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (!upd.group_update[0]) |=> $stable(ab_offset_out))
        else $error("active copy changed without update");
    a_pulse_flag: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (sync_pin_in && update_source_select[`AB_OFFSET_LSB + `SRC_SYNC]) |=> update_out[0])
        else $error("enabled event did not update");
    a_aboff_quiet: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (update_source_select[`AB_OFFSET_LSB +: 4] == '0) |=> !update_out[0])
        else $error("ab offset updated while masked");
    a_aboff_shadow: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        upd.group_write[0] |=> shadow[0] == $past(wdata_in))
        else $error("ab offset shadow write lost");

    //------------------------------------------------------------
    // cd offset group
    //------------------------------------------------------------
    a_cdoff_write: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (wr_in && addr_in == `CD_OFFSET_ADDR
            && update_source_select[`CD_OFFSET_LSB + `SRC_WRITE])
        |=> cd_offset_out == $past(wdata_in))
        else $error("cd offset auto update missed");
    a_cdoff_strobe: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (strobe && update_source_select[`CD_OFFSET_LSB + `SRC_STROBE] && !wr_in)
        |=> cd_offset_out == $past(shadow[1]))
        else $error("cd offset strobe update missed");
    a_sync_update_cd: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (sync_pin_in && update_source_select[`CD_OFFSET_LSB + `SRC_SYNC] && !wr_in)
        |=> cd_offset_out == $past(shadow[1]))
        else $error("cd offset sync update missed");
    a_cdoff_timing: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (timing_reference_pin_in && update_source_select[`CD_OFFSET_LSB + `SRC_TIMING]
            && !wr_in)
        |=> cd_offset_out == $past(shadow[1]))
        else $error("cd offset timing update missed");
    a_cdoff_hold: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (!upd.group_update[1]) |=> $stable(cd_offset_out))
        else $error("cd offset changed without update");
    a_cdoff_quiet: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (update_source_select[`CD_OFFSET_LSB +: 4] == '0) |=> !update_out[1])
        else $error("cd offset updated while masked");
    a_cdoff_shadow: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        upd.group_write[1] |=> shadow[1] == $past(wdata_in))
        else $error("cd offset shadow write lost");

    //------------------------------------------------------------
    // ab correction group
    //------------------------------------------------------------
    a_abcor_write: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (wr_in && addr_in == `AB_CORRECTION_ADDR
            && update_source_select[`AB_CORRECTION_LSB + `SRC_WRITE])
        |=> ab_correction_out == $past(wdata_in))
        else $error("ab correction auto update missed");
    a_abcor_strobe: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (strobe && update_source_select[`AB_CORRECTION_LSB + `SRC_STROBE] && !wr_in)
        |=> ab_correction_out == $past(shadow[2]))
        else $error("ab correction strobe update missed");
    a_abcor_sync: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (sync_pin_in && update_source_select[`AB_CORRECTION_LSB + `SRC_SYNC] && !wr_in)
        |=> ab_correction_out == $past(shadow[2]))
        else $error("ab correction sync update missed");
    a_timing_update_ab: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (timing_reference_pin_in && update_source_select[`AB_CORRECTION_LSB + `SRC_TIMING]
            && !wr_in)
        |=> ab_correction_out == $past(shadow[2]))
        else $error("ab correction timing update missed");
    a_abcor_hold: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (!upd.group_update[2]) |=> $stable(ab_correction_out))
        else $error("ab correction changed without update");
    a_masked_quiet: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (update_source_select[`AB_CORRECTION_LSB +: 4] == '0) |=> !update_out[2])
        else $error("masked group updated");
    a_abcor_shadow: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        upd.group_write[2] |=> shadow[2] == $past(wdata_in))
        else $error("ab correction shadow write lost");

    //------------------------------------------------------------
    // cd correction group
    //------------------------------------------------------------
    a_cdcor_write: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (wr_in && addr_in == `CD_CORRECTION_ADDR
            && update_source_select[`CD_CORRECTION_LSB + `SRC_WRITE])
        |=> cd_correction_out == $past(wdata_in))
        else $error("cd correction auto update missed");
    a_strobe_update_cd: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (strobe && update_source_select[`CD_CORRECTION_LSB + `SRC_STROBE] && !wr_in)
        |=> cd_correction_out == $past(shadow[3]))
        else $error("cd correction strobe update missed");
    a_cdcor_sync: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (sync_pin_in && update_source_select[`CD_CORRECTION_LSB + `SRC_SYNC] && !wr_in)
        |=> cd_correction_out == $past(shadow[3]))
        else $error("cd correction sync update missed");
    a_cdcor_timing: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (timing_reference_pin_in && update_source_select[`CD_CORRECTION_LSB + `SRC_TIMING]
            && !wr_in)
        |=> cd_correction_out == $past(shadow[3]))
        else $error("cd correction timing update missed");
    a_cdcor_hold: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (!upd.group_update[3]) |=> $stable(cd_correction_out))
        else $error("cd correction changed without update");
    a_cdcor_quiet: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (update_source_select[`CD_CORRECTION_LSB +: 4] == '0) |=> !update_out[3])
        else $error("cd correction updated while masked");
    a_cdcor_shadow: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        upd.group_write[3] |=> shadow[3] == $past(wdata_in))
        else $error("cd correction shadow write lost");
endmodule // qmc_update_sync_select
`default_nettype wire

/* design/qmc_update_params.svh */
// constants for the quadrature correction update source selection block
`ifndef QMC_UPDATE_PARAMS_SVH
`define QMC_UPDATE_PARAMS_SVH

`define ADDR_W              6
`define DATA_W              16
`define UPDATE_SOURCE_SELECT_ADDR   6'h1e
`define UPDATE_SOURCE_SELECT_RESET  16'h1111
`define STROBE_CTRL_ADDR    6'h1f
`define STROBE_BIT          1
`define AB_OFFSET_ADDR      6'h10
`define CD_OFFSET_ADDR      6'h11
`define AB_CORRECTION_ADDR  6'h12
`define CD_CORRECTION_ADDR  6'h13
`define AB_OFFSET_LSB       12
`define CD_OFFSET_LSB       8
`define AB_CORRECTION_LSB   4
`define CD_CORRECTION_LSB   0
`define SRC_STROBE          3
`define SRC_SYNC            2
`define SRC_TIMING          1
`define SRC_WRITE           0
`define NUM_GROUPS          4
`define ZERO_DATA           16'h0000

`endif

/* design/qmc_update_pkg.sv */
// types for the quadrature correction update source selection block
`default_nettype none
package qmc_update_pkg;
    typedef logic [3:0]  source_mask_t;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {
        GROUP_AB_OFFSET,
        GROUP_CD_OFFSET,
        GROUP_AB_CORRECTION,
        GROUP_CD_CORRECTION
    } group_t;
endpackage
`default_nettype wire

/* design/qmc_update_if.sv */
// interface carrying per-group update events between the block's modules
`timescale 1ns/1ps
`default_nettype none
interface qmc_update_if;
    logic [3:0] group_write;
    logic [3:0] group_update;
    modport selector (input group_write, output group_update);
    modport bank     (output group_write, input group_update);
endinterface
`default_nettype wire

/* design/qmc_update_selector.sv */
// combines enabled events into one update per shadow group
`timescale 1ns/1ps
`default_nettype none
`include "qmc_update_params.svh"
module qmc_update_selector (
    input  wire logic [15:0] select_in,
    input  wire logic        strobe_in,
    input  wire logic        sync_in,
    input  wire logic        timing_in,
    qmc_update_if.selector   upd
);
    localparam int LSB [4] = '{`AB_OFFSET_LSB, `CD_OFFSET_LSB,
                               `AB_CORRECTION_LSB, `CD_CORRECTION_LSB};
    genvar g;
    generate
        for (g = 0; g < `NUM_GROUPS; g++) begin : g_grp
            qmc_update_pkg::source_mask_t m;
            assign m = select_in[LSB[g] +: 4];
            // any enabled event fires the update
            assign upd.group_update[g] = (m[`SRC_STROBE] & strobe_in)
                                       | (m[`SRC_SYNC]   & sync_in)
                                       | (m[`SRC_TIMING] & timing_in)
                                       | (m[`SRC_WRITE]  & upd.group_write[g]);
        end
    endgenerate
endmodule // qmc_update_selector
`default_nettype wire

/* bench/sync_source.sv */
// far-side model: board logic pulsing the sync and timing reference pins
`timescale 1ns/1ps
`default_nettype none
module sync_source (
    input  wire logic clk_in,
    input  wire logic go_sync_in,
    input  wire logic go_tim_in,
    output logic      sync_out = 1'b0,
    output logic      tim_out  = 1'b0
);
    // pins rest low and rise for one clock per request
    always_ff @(posedge clk_in) begin
        sync_out <= go_sync_in;
        tim_out  <= go_tim_in;
    end
endmodule // sync_source
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the update source selection block
`timescale 1ns/1ps
`default_nettype none
`include "qmc_update_params.svh"
module tb_top;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic [5:0]  addr       = 6'h00;
    logic [15:0] wdata      = 16'h0000;
    logic        wr_en      = 1'b0;
    logic        rd_en      = 1'b0;
    logic        go_sync    = 1'b0;
    logic        go_tim     = 1'b0;
    logic        p          = 1'b0;
    wire logic   sync_pin;
    wire logic   tim_pin;
    logic [15:0] rdata;
    logic [15:0] act [4];
    logic [15:0] exp_act [4] = '{4{16'h0000}};
    logic [3:0]  upd;
    logic [15:0] rq [$];
    logic [3:0]  uq [$];
    logic [15:0] v;
    int          mismatches  = 0;
    int          comparisons = 0;
    int          seed        = 32'hdd66656e;
    qmc_update_sync_select u_qmc_update_sync_select (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_en), .rd_in(rd_en),
        .sync_pin_in(sync_pin), .timing_reference_pin_in(tim_pin), .rdata_out(rdata),
        .ab_offset_out(act[0]), .cd_offset_out(act[1]), .ab_correction_out(act[2]),
        .cd_correction_out(act[3]), .update_out(upd));
    sync_source u_sync_source (.clk_in(clk_sys_in), .go_sync_in(go_sync),
        .go_tim_in(go_tim), .sync_out(sync_pin), .tim_out(tim_pin));
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    //------------------------------------------------------------
    // tasks
    //------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys_in) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
        @(posedge clk_sys_in) wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        rq.push_back(e);
        @(posedge clk_sys_in) begin addr <= a; rd_en <= 1'b1; end
        @(posedge clk_sys_in) rd_en <= 1'b0;
    endtask
    task automatic pulse(input int s);
        @(posedge clk_sys_in) begin go_sync <= (s == 2); go_tim <= (s == 1); end
        @(posedge clk_sys_in) begin go_sync <= 1'b0; go_tim <= 1'b0; end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // read data stands one cycle after the strobe; updates must match notes
    always @(posedge clk_sys_in) begin
        if (p) chk("rdata", rq.size() ? rq.pop_front() : 16'hdead, rdata);
        if (rst_n_in && upd !== 4'h0) begin
            chk("update", uq.size() ? uq.pop_front() : 4'h0, upd);
        end
        p = rd_en;
    end
    initial begin
        #200000;
        mismatches++;
        final_report;
    end
    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(`UPDATE_SOURCE_SELECT_ADDR, `UPDATE_SOURCE_SELECT_RESET);
        rd(6'h05, 16'h0000);
        for (int g = 0; g < 4; g++) begin
            for (int s = 0; s < 4; s++) begin
                wr(`UPDATE_SOURCE_SELECT_ADDR, 16'h1 << (12 - 4 * g + s));
                v = 16'($random(seed));
                if (s == 0) uq.push_back(4'h1 << g);
                wr(`AB_OFFSET_ADDR + 6'(g), v);
                rd(`AB_OFFSET_ADDR + 6'(g), v);
                if (s != 0) chk("held", exp_act[g], act[g]);
                if (s == 3) begin
                    repeat (4) uq.push_back(4'h1 << g);
                    wr(`STROBE_CTRL_ADDR, 16'h1 << `STROBE_BIT);
                    rd(`STROBE_CTRL_ADDR, 16'h1 << `STROBE_BIT);
                    wr(`STROBE_CTRL_ADDR, 16'h0000);
                end else if (s != 0) begin
                    uq.push_back(4'h1 << g);
                    pulse(s);
                end
                repeat (3) @(posedge clk_sys_in);
                chk("active", v, act[g]);
                exp_act[g] = v;
            end
            $display("test group %0d done", g);
        end
        for (int s = 1; s < 3; s++) begin
            wr(`UPDATE_SOURCE_SELECT_ADDR, 16'h1111 << s);
            for (int g = 0; g < 4; g++) begin
                exp_act[g] = 16'($random(seed));
                wr(`AB_OFFSET_ADDR + 6'(g), exp_act[g]);
            end
            uq.push_back(4'hf);
            pulse(s);
            repeat (3) @(posedge clk_sys_in);
            for (int g = 0; g < 4; g++) chk("all", exp_act[g], act[g]);
        end
        $display("test multi source done");
        @(posedge clk_sys_in) rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(`UPDATE_SOURCE_SELECT_ADDR, `UPDATE_SOURCE_SELECT_RESET);
        chk("reset active", 16'h0000, act[0]);
        $display("test reset done");
        for (int i = 0; i < 20 && (rq.size() || uq.size()); i++) @(posedge clk_sys_in);
        if (rq.size() || uq.size()) mismatches++;
        final_report;
    end
endmodule // tb_top
`default_nettype wire
